// >>> dac_serial_write_and_powerdown_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dac_serial_write_and_powerdown_tb;
  logic          clk = 1'b0;
  logic          reset = 1'b1;
  logic          wr_valid = 1'b0;
  logic          wr_ready;
  logic [1:0]    wr_mode = 2'h0;
  logic [9:0]    wr_code = 10'h000;
  logic [9:0]    code_a, code_b;
  logic [1:0]    mode_a, mode_b;
  logic          t1k, t100k, an_on, amp, upd, abort_b, busy;
  logic [1023:0] tap;
  logic [15:0]   wire_word;
  logic [11:0]   q[$];
  int            n_fail = 0, num_checks = 0, seed = 14, nbits = 0, n_abort = 0;
  dacsw_if link_a();
  dacsw_if link_b();
  always #25 clk = ~clk;
  dacsw_host dacsw_host_i (.CLK(clk), .RESET(reset), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_MODE(wr_mode), .WR_CODE(wr_code), .BUSY(busy), .link(link_a));
  dacsw_device dacsw_device_i (.CLK(clk), .RESET(reset), .link(link_a), .DAC_CODE(code_a),
    .MODE(mode_a), .ANALOG_ON(an_on), .TERM_1K(t1k), .TERM_100K(t100k), .AMP_TO_PIN(amp),
    .TAP_SEL(tap), .UPDATE(upd), .ABORT());
  dacsw_device dacsw_device_b_i (.CLK(clk), .RESET(reset), .link(link_b), .DAC_CODE(code_b),
    .MODE(mode_b), .ANALOG_ON(), .TERM_1K(), .TERM_100K(), .AMP_TO_PIN(), .TAP_SEL(),
    .UPDATE(), .ABORT(abort_b));
  dacsw_chk dacsw_chk_i (.CLK(clk), .RESET(reset), .sync_n(link_a.sync_n), .sclk(link_a.sclk),
    .DAC_CODE(code_a), .MODE(mode_a), .TERM_1K(t1k), .TERM_100K(t100k), .AMP_TO_PIN(amp),
    .TAP_SEL(tap), .UPDATE(upd));
  // ****
  // Tasks
  // ****
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task results;
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task push(input logic [1:0] m, input logic [9:0] c);
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_mode <= m;
    wr_code <= c;
    @(negedge clk);
    while (wr_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    wr_valid <= 1'b0;
    q.push_back({m, c});
  endtask : push
  task frame_b(input logic [15:0] w, input int n);
    repeat (4) @(posedge clk);
    link_b.sync_n <= 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      @(posedge clk);
      link_b.din <= w[i];
      link_b.sclk <= 1'b1;
      repeat (4) @(posedge clk);
      link_b.sclk <= 1'b0;
      repeat (3) @(posedge clk);
      if (i == 8) repeat (12) @(posedge clk);
    end
    @(posedge clk);
    link_b.sync_n <= 1'b1;
    // Released data line flips so a stale bit cannot pass
    link_b.din <= ~w[16 - n];
    repeat (8) @(posedge clk);
  endtask : frame_b
  // ****
  // Model and monitors
  // ****
  always @(posedge clk) if (abort_b === 1'b1) n_abort++;
  always @(negedge link_a.sync_n) nbits = 0;
  always @(negedge link_a.sclk) if (link_a.sync_n === 1'b0) begin
    wire_word = {wire_word[14:0], link_a.din};
    nbits++;
    if (nbits == 16) check(wire_word, {2'h0, q[0], 2'h0});
  end
  initial begin
    logic [11:0] e;
    forever begin
      @(negedge clk);
      if (upd === 1'b1) begin
        repeat (3) @(negedge clk);
        e = q.pop_front();
        check({4'h0, mode_a, code_a}, {4'h0, e});
        check({13'h0, t1k, t100k, an_on}, {13'h0, e[11:10] == 2'h1, e[11:10] == 2'h2,
          e[11:10] == 2'h0});
        check({15'h0, tap[code_a]}, 16'h1);
      end
    end
  end
  initial begin
    #400000;
    n_fail++;
    results;
  end
  initial begin
    link_b.sync_n <= 1'b1;
    link_b.sclk <= 1'b0;
    link_b.din <= 1'b0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check({4'h0, mode_a, code_a}, 16'h0);
    for (int k = 0; k < 9; k++) push(k[1:0], k == 8 ? 10'h3ff : 10'($random(seed)));
    @(negedge clk);
    check({14'h0, wr_ready, busy}, 16'h1);
    for (int t = 0; t < 4000 && q.size() > 0; t++) @(posedge clk);
    check(16'(q.size()), 16'h0);
    check({14'h0, busy, link_a.sync_n}, 16'h0);
    frame_b(16'hca5f, 16);
    check({4'h0, mode_b, code_b}, 16'h0297);
    frame_b(16'h3000, 15);
    check({4'h0, mode_b, code_b}, 16'h0297);
    check(16'(n_abort), 16'h1);
    results;
  end
endmodule : dac_serial_write_and_powerdown_tb
`default_nettype wire

// >>> dacsw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dacsw_chk (
  input wire logic          CLK,
  input wire logic          RESET,
  input wire logic          sync_n,
  input wire logic          sclk,
  input wire logic [9:0]    DAC_CODE,
  input wire logic [1:0]    MODE,
  input wire logic          TERM_1K,
  input wire logic          TERM_100K,
  input wire logic          AMP_TO_PIN,
  input wire logic [1023:0] TAP_SEL,
  input wire logic          UPDATE
);
  // ****
  // Checks
  // ****
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  chk_tap_onehot: assert property ($onehot(TAP_SEL))
    else $error("tap select not one-hot");
  chk_tap_code: assert property ($stable(DAC_CODE) |-> TAP_SEL[DAC_CODE])
    else $error("tap differs from code");
  chk_term_low: assert property ($stable(MODE) |-> TERM_1K == (MODE == 2'h1))
    else $error("low termination wrong");
  chk_term_high: assert property ($stable(MODE) |-> TERM_100K == (MODE == 2'h2))
    else $error("high termination wrong");
  chk_amp_path: assert property ($stable(MODE) |-> AMP_TO_PIN == (MODE == 2'h0))
    else $error("amplifier path wrong");
  chk_code_hold: assert property ($changed(DAC_CODE) |->
    $past(UPDATE) || $past(UPDATE, 2) || $past(UPDATE, 3))
    else $error("code changed without update");
  chk_mode_hold: assert property ($changed(MODE) |->
    $past(UPDATE) || $past(UPDATE, 2) || $past(UPDATE, 3))
    else $error("mode changed without update");
  chk_update_pulse: assert property (UPDATE |=> !UPDATE [*8])
    else $error("update pulse too long");
  chk_idle_clock: assert property (sync_n |-> !sclk)
    else $error("serial clock not idle low");
endmodule : dacsw_chk
`default_nettype wire

// >>> dacsw_device.sv
`timescale 1ns/1ps
`default_nettype none
module dacsw_device (
  input  wire logic          CLK,
  input  wire logic          RESET,
  dacsw_if.device            link,
  output logic [9:0]         DAC_CODE,
  output logic [1:0]         MODE,
  output logic               ANALOG_ON,
  output logic               TERM_1K,
  output logic               TERM_100K,
  output logic               AMP_TO_PIN,
  output logic [1023:0]      TAP_SEL,
  output logic               UPDATE,
  output logic               ABORT
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Reset to the parked-low level, so a select held low gives no false fall
  logic sync_lvl;
  logic sync_fall;
  logic sync_rise;
  logic sclk_fall;
  logic din_lvl;

  dacsw_sync #(.INIT(1'b0)) sync_pin_i (
    .clk   (CLK),
    .reset (RESET),
    .pin   (link.sync_n),
    .level (sync_lvl),
    .rise  (sync_rise),
    .fall  (sync_fall)
  );

  dacsw_sync #(.INIT(1'b0)) sclk_pin_i (
    .clk   (CLK),
    .reset (RESET),
    .pin   (link.sclk),
    .level (),
    .rise  (),
    .fall  (sclk_fall)
  );

  dacsw_sync #(.INIT(1'b0)) din_pin_i (
    .clk   (CLK),
    .reset (RESET),
    .pin   (link.din),
    .level (din_lvl),
    .rise  (),
    .fall  ()
  );

  // ****************************************
  // Frame shifter
  // ****************************************
  logic [15:0] shift_reg;
  logic [4:0]  count_reg;
  logic        armed_reg;
  logic        last_bit;
  logic [15:0] word;

  assign last_bit = armed_reg && !sync_lvl && sclk_fall &&
                    (count_reg == 5'(dacsw_pkg::WORD_BITS - 1));
  assign word     = {shift_reg[14:0], din_lvl};

  always_ff @(posedge CLK) begin
    if (RESET) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else if (sync_lvl) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else if (sync_fall) begin
      count_reg <= 5'h00;
      armed_reg <= 1'b1;
      if (sclk_fall) begin
        shift_reg <= {15'h0000, din_lvl};
        count_reg <= 5'h01;
      end
    end else if (armed_reg && sclk_fall) begin
      shift_reg <= word;
      count_reg <= count_reg + 5'h01;
      // Later clocks of a finished frame are ignored until a fresh fall
      if (last_bit) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Converter and mode registers
  // ****************************************
  logic [9:0] code_reg;
  logic [1:0] mode_reg;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      code_reg <= dacsw_pkg::CODE_RESET;
      mode_reg <= 2'(dacsw_pkg::DACSW_NORMAL);
    end else if (last_bit) begin
      code_reg <= word[dacsw_pkg::CODE_LSB +: dacsw_pkg::CODE_BITS];
      mode_reg <= {word[dacsw_pkg::MODE_UPPER], word[dacsw_pkg::MODE_LOWER]};
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      UPDATE <= 1'b0;
      ABORT  <= 1'b0;
    end else begin
      UPDATE <= last_bit;
      ABORT  <= sync_rise && armed_reg && (count_reg != 5'h00);
    end
  end

  // Registered copies keep outputs glitch free
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DAC_CODE <= dacsw_pkg::CODE_RESET;
      TAP_SEL  <= 1024'h1;
    end else begin
      DAC_CODE <= code_reg;
      // Taps stay one-hot even when powered down; string power is cut instead
      TAP_SEL  <= 1024'h1 << code_reg;
    end
  end

  // Power-down decode; the stored code is left alone in every mode
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MODE       <= 2'h0;
      ANALOG_ON  <= 1'b1;
      AMP_TO_PIN <= 1'b1;
      TERM_1K    <= 1'b0;
      TERM_100K  <= 1'b0;
    end else begin
      MODE       <= mode_reg;
      ANALOG_ON  <= (mode_reg == 2'(dacsw_pkg::DACSW_NORMAL));
      AMP_TO_PIN <= (mode_reg == 2'(dacsw_pkg::DACSW_NORMAL));
      TERM_1K    <= (mode_reg == 2'(dacsw_pkg::DACSW_PD_1K));
      TERM_100K  <= (mode_reg == 2'(dacsw_pkg::DACSW_PD_100K));
    end
  end
endmodule : dacsw_device

// ****************************************
// Two-flop synchroniser with edge flags
// ****************************************
module dacsw_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic [1:0] meta_reg;
  logic       last_reg;

  // Only the second stage feeds logic; the first may still be settling
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= {2{INIT}};
    end else begin
      meta_reg <= {meta_reg[0], pin};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      last_reg <= INIT;
    end else begin
      last_reg <= meta_reg[1];
    end
  end

  assign level = meta_reg[1];
  assign rise  = !last_reg && meta_reg[1];
  assign fall  = last_reg && !meta_reg[1];
endmodule : dacsw_sync
`default_nettype wire

// >>> dacsw_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dacsw_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : dacsw_fifo
`default_nettype wire

// >>> dacsw_host.sv
`timescale 1ns/1ps
`default_nettype none
module dacsw_host #(
  parameter int SCLK_HALF = dacsw_pkg::SCLK_HALF_DEFAULT
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        WR_VALID,
  output logic             WR_READY,
  input  wire logic [1:0]  WR_MODE,
  input  wire logic [9:0]  WR_CODE,
  output logic             BUSY,
  dacsw_if.host            link
);
  typedef enum logic [1:0] {HS_IDLE, HS_GAP, HS_SHIFT, HS_DONE} dacsw_hstate_t;

  // ****************************************
  // Word FIFO
  // ****************************************
  logic                   f_valid;
  logic                   f_ready;
  logic [15:0]            f_word;
  logic [15:0]            in_word;
  assign in_word = {2'h0, WR_MODE, WR_CODE, 2'h0};

  dacsw_fifo #(.WIDTH(16), .DEPTH(dacsw_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .reset     (RESET),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   (in_word),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word)
  );

  // ****************************************
  // Serial engine
  // ****************************************
  dacsw_hstate_t  state_reg;
  logic [15:0]    shift_reg;
  logic [4:0]     bits_reg;
  logic [7:0]     div_reg;
  logic           sync_n_reg;
  logic           sclk_reg;
  logic           din_reg;
  logic           tick;

  assign tick    = (div_reg == 8'(SCLK_HALF - 1));
  assign f_ready = (state_reg == HS_IDLE) && tick;
  assign link.sync_n = sync_n_reg;
  assign link.sclk   = sclk_reg;
  assign link.din    = din_reg;

  // Divider keeps SCLK far below the device ceiling
  always_ff @(posedge CLK) begin
    if (RESET || tick) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg  <= HS_IDLE;
      sync_n_reg <= 1'b0;
      sclk_reg   <= 1'b0;
      din_reg    <= 1'b0;
      shift_reg  <= 16'h0000;
      bits_reg   <= 5'h00;
      BUSY       <= 1'b0;
    end else if (tick) begin
      unique case (state_reg)
        HS_IDLE: begin
          if (f_valid) begin
            shift_reg  <= f_word;
            sync_n_reg <= 1'b1;
            BUSY       <= 1'b1;
            state_reg  <= HS_GAP;
          end
        end
        HS_GAP: begin
          sync_n_reg <= 1'b0;
          din_reg    <= shift_reg[15];
          shift_reg  <= {shift_reg[14:0], 1'b0};
          bits_reg   <= 5'h00;
          state_reg  <= HS_SHIFT;
        end
        HS_SHIFT: begin
          sclk_reg <= ~sclk_reg;
          if (sclk_reg) begin
            bits_reg <= bits_reg + 5'h01;
            if (bits_reg == 5'(dacsw_pkg::WORD_BITS - 1)) begin
              state_reg <= HS_DONE;
            end
          end else if (bits_reg != 5'h00) begin
            din_reg   <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
          end
        end
        HS_DONE: begin
          din_reg   <= 1'b0;
          state_reg <= HS_IDLE;
          BUSY      <= 1'b0;
        end
      endcase
    end
  end
endmodule : dacsw_host
`default_nettype wire

// >>> dacsw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dacsw_if;
  logic sync_n;
  logic sclk;
  logic din;
  modport host   (output sync_n, output sclk, output din);
  modport device (input sync_n, input sclk, input din);
endinterface : dacsw_if
`default_nettype wire

// >>> dacsw_pkg.sv
`default_nettype none
package dacsw_pkg;
  // ****************************************
  // Word layout
  // ****************************************
  localparam int WORD_BITS  = 16;
  localparam int CODE_BITS  = 10;
  localparam int CODE_LSB   = 2;
  localparam int MODE_UPPER = 13;
  localparam int MODE_LOWER = 12;
  localparam logic [9:0] CODE_RESET = 10'h000;

  typedef enum logic [1:0] {
    DACSW_NORMAL = 2'h0,
    DACSW_PD_1K  = 2'h1,
    DACSW_PD_100K = 2'h2,
    DACSW_PD_HIZ = 2'h3
  } dacsw_mode_t;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS    = 50;
  localparam int SYNC_HIGH_MIN_NS = 33;
  localparam int SYNC_HIGH_CYCLES =
    (SYNC_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_MAX_MHZ     = 30;
  localparam int SCLK_HALF_DEFAULT = 4;
  localparam int BITCNT_W         = 5;
  localparam int FIFO_DEPTH       = 8;
endpackage : dacsw_pkg
`default_nettype wire
